// ===== flash_prot.sv
// flash_prot: flash mode control, block protect and hardware protect
// assumes axi4-lite master on clk, pins synchronous to clk
//
// Overview of operation
// RULE1: software prewrites whole array to zero first
// RULE2: all mode bits clear selects prewrite-verify
// RULE3: prewrite-verify applies verify level, reads return data
// RULE4: software waits four microseconds before verify read
// RULE5: software protect blocks program and erase entry
// RULE6: block bits protect individually; verify stays usable
// RULE7: block regs F0 and 00 protect all
// RULE8: hardware protect stops operation, clears registers
// RULE9: missing 12 volt clears registers, disables modes
// RULE10: reset and low-power modes clear and protect
// RULE11: external reset held low 20 ms at power-on
// RULE12: running reset held low ten clocks minimum
// RULE13: hardware protect disables erase for every block
// RULE14: software masks interrupts while program/erase set
// RULE15: enter program/erase only when mode, block, no protect
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module flash_prot (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // protection inputs
   input  wire logic        program_voltage_ok,
   input  wire logic        external_reset_pin_n,
   input  wire logic        watchdog_reset,
   input  wire logic        sleep_mode,
   input  wire logic        subsleep_mode,
   input  wire logic        watch_mode,
   input  wire logic        standby_mode,
   // flash array controls
   input  wire logic [3:0]  target_block,
   input  wire logic        target_large,
   output logic             program_active,
   output logic             erase_active,
   output logic             prewrite_verify_active,
   output logic             program_verify_active,
   output logic             erase_verify_active,
   output logic             verify_settled,
   output logic [11:0]      erase_block_select,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic [7:0]  flash_mode_control_reg_q;
   logic [7:0]  erase_block_reg_one_q;
   logic [7:0]  erase_block_reg_two_q;
   logic [9:0]  settle_q;
   logic        aw_held_q;
   logic        w_held_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wstrb0_q;

   // hardware protect: voltage, any reset, low-power modes
   wire hw_protect = !program_voltage_ok || !external_reset_pin_n ||
                     watchdog_reset || sleep_mode || subsleep_mode ||
                     watch_mode || standby_mode; // see RULE9 see RULE10

   wire prog_bit  = flash_mode_control_reg_q[flash_prot_pkg::prog_mode_pos];
   wire erase_bit = flash_mode_control_reg_q[flash_prot_pkg::erase_mode_pos];
   wire pv_bit    = flash_mode_control_reg_q[flash_prot_pkg::prog_verify_pos];
   wire ev_bit    = flash_mode_control_reg_q[flash_prot_pkg::erase_verify_pos];
   wire sw_prot   = flash_mode_control_reg_q[flash_prot_pkg::sw_protect_pos];

   // twelve blocks: four large in reg one low nibble, eight small in reg two
   wire [11:0] block_en = {erase_block_reg_two_q,
                           erase_block_reg_one_q[3:0]};
   wire [11:0] block_sel = hw_protect ? 12'h000 : block_en; // see RULE13
   wire [3:0]  tgt_idx   = target_large ? {2'h0, target_block[1:0]}
                                        : {1'b0, target_block[2:0]} + 4'h4;
   wire        tgt_en    = block_sel[tgt_idx]; // see RULE6 see RULE7

   // entry gated by block enable and both protections
   wire prog_go  = prog_bit && !erase_bit && tgt_en && !sw_prot &&
                   !hw_protect; // see RULE5 see RULE15
   wire erase_go = erase_bit && !prog_bit && tgt_en && !sw_prot &&
                   !hw_protect; // see RULE5 see RULE15
   // verify modes ignore block protect but not hardware protect
   wire pw_go    = !prog_bit && !erase_bit && !pv_bit && !ev_bit &&
                   !hw_protect; // see RULE2 see RULE3
   wire pv_go    = pv_bit && !prog_bit && !erase_bit && !hw_protect;
   wire ev_go    = ev_bit && !prog_bit && !erase_bit && !hw_protect;

   // axi write path: address and data taken in either order
   // a channel counts only once taken, so ready never waits on valid
   wire take_aw = s_axi_awvalid && s_axi_awready;
   wire take_w  = s_axi_wvalid && s_axi_wready;
   wire aw_ok   = aw_held_q || take_aw;
   wire w_ok    = w_held_q || take_w;
   wire do_wr   = aw_ok && w_ok && !s_axi_bvalid;
   wire b_busy  = s_axi_bvalid && !s_axi_bready;
   wire [7:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr;
   wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
   wire       ws = w_held_q ? wstrb0_q : s_axi_wstrb[0];
   wire wr_mode = do_wr && ws && wa == flash_prot_pkg::mode_ctrl_off;
   wire wr_one  = do_wr && ws && wa == flash_prot_pkg::block_one_off;
   wire wr_two  = do_wr && ws && wa == flash_prot_pkg::block_two_off;
   wire wr_hit  = wa == flash_prot_pkg::mode_ctrl_off ||
                  wa == flash_prot_pkg::block_one_off ||
                  wa == flash_prot_pkg::block_two_off;

   wire [7:0] status = {1'b0, settle_q == 10'h000, hw_protect, ev_go,
                        pv_go, pw_go, erase_go, prog_go};
   wire [7:0] ra = s_axi_araddr;
   wire [7:0] rd =
      ra == flash_prot_pkg::mode_ctrl_off ? flash_mode_control_reg_q :
      ra == flash_prot_pkg::block_one_off ? erase_block_reg_one_q :
      ra == flash_prot_pkg::block_two_off ? erase_block_reg_two_q :
      ra == flash_prot_pkg::status_off    ? status : 8'h00;
   wire rd_hit = ra == flash_prot_pkg::mode_ctrl_off ||
                 ra == flash_prot_pkg::block_one_off ||
                 ra == flash_prot_pkg::block_two_off ||
                 ra == flash_prot_pkg::status_off;
   wire do_rd  = s_axi_arvalid && !s_axi_rvalid;

   // protection clears every control register, overriding writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_mode_control_reg_q <= flash_prot_pkg::mode_ctrl_rst;
         erase_block_reg_one_q    <= flash_prot_pkg::block_one_rst;
         erase_block_reg_two_q    <= flash_prot_pkg::block_two_rst;
      end else if (hw_protect) begin
         flash_mode_control_reg_q <= flash_prot_pkg::mode_ctrl_rst; // see RULE8
         erase_block_reg_one_q    <= flash_prot_pkg::block_one_rst; // see RULE8
         erase_block_reg_two_q    <= flash_prot_pkg::block_two_rst;
      end else begin
         if (wr_mode) flash_mode_control_reg_q <= wd[7:0];
         if (wr_one)
            erase_block_reg_one_q <= wd[7:0] | ~flash_prot_pkg::block_one_mask;
         if (wr_two) erase_block_reg_two_q <= wd[7:0];
      end
   end

   // settle counter restarts whenever no verify mode (prewrite, program or erase) is selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) settle_q <= flash_prot_pkg::settle_count;
      else if (!(pw_go || pv_go || ev_go))
         settle_q <= flash_prot_pkg::settle_count; // see RULE4
      else if (settle_q != 10'h000) settle_q <= settle_q - 10'h001;
   end

   // mode outputs registered so array strobes never glitch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         program_active         <= 1'b0;
         erase_active           <= 1'b0;
         prewrite_verify_active <= 1'b0;
         program_verify_active  <= 1'b0;
         erase_verify_active    <= 1'b0;
         verify_settled         <= 1'b0;
         erase_block_select     <= 12'h000;
      end else begin
         program_active         <= prog_go;
         erase_active           <= erase_go;
         prewrite_verify_active <= pw_go; // see RULE3
         program_verify_active  <= pv_go; // see RULE6
         erase_verify_active    <= ev_go;
         verify_settled         <= (pw_go || pv_go || ev_go) &&
                                   settle_q == 10'h000;
         erase_block_select     <= erase_bit ? block_sel : 12'h000;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= flash_prot_pkg::resp_okay;
      end else begin
         s_axi_awready <= !do_wr && !b_busy && !aw_held_q && !take_aw;
         s_axi_wready  <= !do_wr && !b_busy && !w_held_q && !take_w;
         if (take_aw && !do_wr) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (take_w && !do_wr) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? flash_prot_pkg::resp_okay
                                   : flash_prot_pkg::resp_slverr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= flash_prot_pkg::resp_okay;
      end else begin
         s_axi_arready <= do_rd && !s_axi_arready;
         if (do_rd && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd};
            s_axi_rresp  <= rd_hit ? flash_prot_pkg::resp_okay
                                   : flash_prot_pkg::resp_slverr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== flash_prot_pkg.sv
// flash_prot_pkg: register map, field positions and reset values
// assumes a 32-bit axi4-lite register bus and a 125 mhz system clock
package flash_prot_pkg;
   // register byte offsets
   localparam logic [7:0] mode_ctrl_off    = 8'h00;
   localparam logic [7:0] block_one_off    = 8'h04;
   localparam logic [7:0] block_two_off    = 8'h08;
   localparam logic [7:0] status_off       = 8'h0C;
   localparam logic [7:0] power_ctrl_off   = 8'h10;
   // mode control fields
   localparam int         erase_verify_pos = 0;
   localparam int         prog_verify_pos  = 1;
   localparam int         erase_mode_pos   = 2;
   localparam int         prog_mode_pos    = 3;
   localparam int         sw_protect_pos   = 4;
   // status fields
   localparam int         st_program_pos   = 0;
   localparam int         st_erase_pos     = 1;
   localparam int         st_pw_verify_pos = 2;
   localparam int         st_pv_verify_pos = 3;
   localparam int         st_ev_verify_pos = 4;
   localparam int         st_hw_prot_pos   = 5;
   localparam int         st_settled_pos   = 6;
   // reset values: all blocks protected
   localparam logic [7:0] mode_ctrl_rst    = 8'h00;
   localparam logic [7:0] block_one_rst    = 8'hF0;
   localparam logic [7:0] block_two_rst    = 8'h00;
   localparam logic [7:0] block_one_mask   = 8'h0F;
   // prewrite-verify settle time
   localparam int         clk_mhz          = 125;
   localparam int         settle_ns        = 4000;
   localparam int         settle_cycles    = (settle_ns * clk_mhz + 999) / 1000;
   localparam logic [9:0] settle_count     = 10'(settle_cycles);
   // axi responses
   localparam logic [1:0] resp_okay        = 2'h0;
   localparam logic [1:0] resp_slverr      = 2'h2;
endpackage

// ===== flash_prot_props.sv
// flash_prot_props: port checks on the protection and mode outputs
// assumes bind onto flash_prot, one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module flash_prot_props (
   // clock, reset and protection inputs
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        program_voltage_ok,
   input wire logic        external_reset_pin_n,
   input wire logic        watchdog_reset,
   input wire logic        sleep_mode,
   input wire logic        subsleep_mode,
   input wire logic        watch_mode,
   input wire logic        standby_mode,
   // array controls
   input wire logic        program_active,
   input wire logic        erase_active,
   input wire logic        prewrite_verify_active,
   input wire logic        program_verify_active,
   input wire logic        erase_verify_active,
   input wire logic        verify_settled,
   input wire logic [11:0] erase_block_select
);
   wire logic       lp = sleep_mode || subsleep_mode || watch_mode
                         || standby_mode;
   wire logic       hwp = lp || !program_voltage_ok || watchdog_reset
                          || !external_reset_pin_n;
   wire logic       vfy = prewrite_verify_active || program_verify_active
                          || erase_verify_active;
   logic [9:0]      vcnt_q;
   // saturates so a long verify never wraps into a false short count
   wire logic [9:0] vcnt_d = !vfy ? 10'h000
                             : vcnt_q + {9'h000, vcnt_q != 10'h3FF};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) vcnt_q <= 10'h000;
      else vcnt_q <= vcnt_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // two cycles as margin: registers and registered outputs both clear on the first protected edge
   sequence hw_held;
      hwp [*2];
   endsequence
   sequence lp_held;
      lp [*2];
   endsequence
   hw_stops_op_a: assert property (
      hw_held |=> !program_active && !erase_active)
      else $error("program or erase kept under protection");
   hw_no_select_a: assert property (
      hw_held |=> erase_block_select == 12'h000)
      else $error("block select kept under protection");
   vpp_no_verify_a: assert property (
      (!program_voltage_ok) [*2] |=> !vfy)
      else $error("verify kept without programming voltage");
   low_power_a: assert property (
      lp_held |=> !vfy && !program_active && !erase_active)
      else $error("mode kept in low-power state");
   prewrite_only_a: assert property (
      prewrite_verify_active |-> !(program_active || erase_active
         || program_verify_active || erase_verify_active))
      else $error("prewrite-verify overlaps another mode");
   one_mode_a: assert property (
      !(program_active && erase_active))
      else $error("program and erase together");
   settle_wait_a: assert property (
      $rose(vfy) |-> !verify_settled [*8])
      else $error("settled flag too early");
   settle_time_a: assert property (
      verify_settled |-> vcnt_q >= flash_prot_pkg::settle_count)
      else $error("settled before four microseconds");
endmodule
bind flash_prot flash_prot_props u_props (.clk, .rst_n, .program_voltage_ok,
   .external_reset_pin_n, .watchdog_reset, .sleep_mode, .subsleep_mode,
   .watch_mode, .standby_mode, .program_active, .erase_active,
   .prewrite_verify_active, .program_verify_active, .erase_verify_active,
   .verify_settled, .erase_block_select);
`default_nettype wire

// ===== testbench.sv
// testbench: directed checks of flash_prot through axi4-lite
// assumes flash_prot_pkg, flash_prot and its checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk, awr, wrd, bv, arr, rv, pa, ea, pw, pv, ev, vs;
   logic        rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic        arv = 1'b0, rry = 1'b0, tl = 1'b0;
   logic [6:0]  hw = 7'h00;
   logic [3:0]  tb = 4'h0;
   logic [7:0]  aa = 8'h00, ra = 8'h00, wd = 8'h00;
   logic [1:0]  br, rr, rsp;
   logic [11:0] sel;
   logic [31:0] rdat, got;
   int          fails = 0, n_compared = 0, cyc_n = 0;
   flash_prot dut (.clk(clk), .rst_n(rst_n), .program_voltage_ok(!hw[0]),
      .external_reset_pin_n(!hw[1]), .watchdog_reset(hw[2]),
      .sleep_mode(hw[3]), .subsleep_mode(hw[4]), .watch_mode(hw[5]),
      .standby_mode(hw[6]), .target_block(tb), .target_large(tl),
      .program_active(pa), .erase_active(ea), .prewrite_verify_active(pw),
      .program_verify_active(pv), .erase_verify_active(ev),
      .verify_settled(vs), .erase_block_select(sel), .s_axi_awaddr(aa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata({24'h0, wd}),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry));
   task automatic stop_test;
      $display("compared %0d fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // each channel is dropped only at the edge that took it
   task automatic wr(input logic [7:0] a, d);
      aa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (bv !== 1'b1) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end
      bry <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      ra <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      while (rv !== 1'b1) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end
      got = rdat;
      rsp = rr;
      rry <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input string n, input logic [7:0] a, e);
      rd(a);
      chk(n, got, {24'h0, e});
   endtask
   // array taken as already prewritten to zero
   task automatic t_reset;
      rchk("mode", 8'h00, 8'h00);
      rchk("blk1", 8'h04, 8'hF0);
      rchk("blk2", 8'h08, 8'h00);
      rd(8'h14);
      chk("resp", 32'(rsp), 32'(flash_prot_pkg::resp_slverr));
      chk("pwv", 32'(pw), 1);
      chk("setl", 32'(vs), 0);
      cyc(520); // verify read only after settling
      chk("setl", 32'(vs), 1);
      rchk("stat", 8'h0C, 8'h44);
      $display("t_reset done");
   endtask
   task automatic t_prog;
      tl <= 1'b1;
      // no interrupt source reaches this block
      wr(8'h04, 8'h01);
      wr(8'h00, 8'h08);
      cyc(3);
      chk("prog", 32'(pa), 1);
      chk("pwv", 32'(pw), 0);
      tb <= 4'h1;
      cyc(3);
      chk("prog", 32'(pa), 0);
      tb <= 4'h0;
      wr(8'h00, 8'h18);
      cyc(3);
      chk("prog", 32'(pa), 0);
      tb <= 4'h1;
      wr(8'h00, 8'h02);
      cyc(3);
      chk("pvfy", 32'(pv), 1);
      $display("t_prog done");
   endtask
   task automatic t_hw;
      tl <= 1'b0;
      tb <= 4'h0;
      wr(8'h04, 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr(8'h08, 8'h05);
         wr(8'h00, 8'h04);
         cyc(3);
         chk("ers", 32'(ea), 1);
         chk("sel", 32'(sel), 32'h050);
         hw[i] <= 1'b1;
         cyc(10);
         chk("ers", 32'(ea), 0);
         chk("sel", 32'(sel), 0);
         chk("pwv", 32'(pw), 0);
         wr(8'h00, 8'h08);
         hw[i] <= 1'b0;
         cyc(3);
         rchk("mode", 8'h00, 8'h00);
         rchk("blk2", 8'h08, 8'h00);
         rchk("blk1", 8'h04, 8'hF0);
      end
      $display("t_hw done");
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      // power-on hold shortened: no oscillator to settle
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_prog();
      t_hw();
      stop_test();
   end
endmodule
`default_nettype wire
